// File: core/twc_pkg.sv
// Purpose: Shared constants, carrier types and states of the two-wire controller.
// Assumes: An 8-bit register port and a 25 MHz system clock.
// Notes:   Pad bit 0 is the serial clock line and pad bit 1 the serial data line.
package twc_pkg;

	// Register addresses on the firmware port.
	localparam logic [7:0] TWC_ADDR_CFG    = 8'h09;
	localparam logic [7:0] TWC_ADDR_CTL    = 8'h28;
	localparam logic [7:0] TWC_ADDR_DATA   = 8'h29;
	localparam logic [7:0] TWC_ADDR_INT_ST = 8'h2A;
	localparam logic [7:0] TWC_ADDR_INT_EN = 8'h2B;
	localparam logic [7:0] TWC_ADDR_INT_CL = 8'h2C;

	// Configuration register layout and reset value.
	localparam int         TWC_CFG_POS    = 7;
	localparam int         TWC_CFG_WID_HI = 1;
	localparam int         TWC_CFG_WID_LO = 0;
	localparam logic [7:0] TWC_CFG_WMASK  = 8'hB3;
	localparam logic [7:0] TWC_CFG_RST    = 8'h00;

	// Status and control register layout.
	localparam int TWC_CTL_EN    = 0;
	localparam int TWC_CTL_RSTOP = 1;
	localparam int TWC_CTL_ARB   = 2;
	localparam int TWC_CTL_ADDR  = 3;
	localparam int TWC_CTL_ACK   = 4;
	localparam int TWC_CTL_XMIT  = 5;
	localparam int TWC_CTL_CONT  = 6;
	localparam int TWC_CTL_MSTR  = 7;

	// Interrupt status, enable and clear layout.
	localparam int TWC_INT_BYTE = 0;
	localparam int TWC_INT_STOP = 1;
	localparam int TWC_INT_ARB  = 2;

	// Half period of the 100 kHz serial clock, rounded up to whole cycles.
	localparam int         TWC_CLK_NS   = 40;
	localparam int         TWC_HALF_NS  = 5000;
	localparam int         TWC_HALF_CYC = (TWC_HALF_NS + TWC_CLK_NS - 1) / TWC_CLK_NS;
	localparam logic [7:0] TWC_HALF_LD  = 8'(TWC_HALF_CYC - 1);

	// Bit slot numbers within a byte.
	localparam logic [3:0] TWC_BIT_LAST = 4'h7;
	localparam logic [3:0] TWC_BIT_ACK  = 4'h8;
	localparam logic [3:0] TWC_BIT_END  = 4'h9;

	typedef struct packed {
		logic [1:0] o;
		logic [1:0] oe;
	} twc_pad_t;

	typedef struct packed {
		logic enable;
		logic port0;
		logic port1;
		logic port3;
	} twc_par_t;

	typedef enum logic [2:0] {
		TWC_IDLE, TWC_M_START, TWC_M_LOW, TWC_M_HIGH, TWC_M_COND, TWC_S_BIT, TWC_WAIT
	} twc_state_t;

endpackage : twc_pkg

// File: core/twc_ctrl.sv
// Purpose: Two-wire serial controller with the shared serial/parallel pin configuration.
// Assumes: Firmware port on mclk; pad inputs are asynchronous and synchronised here.
// Notes:   Summary of operation follows.
`timescale 1ns/100ps
`default_nettype none

module twc_ctrl
	import twc_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       resetn,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata_q,
	input  wire logic [1:0] p1_pin_in,
	input  wire logic [1:0] p2_pin_in,
	input  wire twc_pad_t   gpio_p1,
	input  wire twc_pad_t   gpio_p2,
	output twc_pad_t        p1_pad_q,
	output twc_pad_t        p2_pad_q,
	output logic      [1:0] p1_open_drain_q,
	output logic      [1:0] p2_open_drain_q,
	output twc_par_t        par_cfg_q,
	output logic            irq_q
);

	// Pads are released or pulled low; GPIO drive passes only when the lines are not ours.
	function automatic twc_pad_t pad_next(input logic mine, input twc_pad_t gp,
	                                      input logic scl_lo, input logic sda_lo);
		twc_pad_t p;
		p = gp;
		if (mine) begin
			p.o  = 2'b00;
			p.oe = {sda_lo, scl_lo};
		end
		return p;
	endfunction : pad_next

	twc_state_t state_q;
	logic [7:0] cfg_q;
	logic [3:0] sync1_q;
	logic [3:0] sync2_q;
	logic       scl_prev_q;
	logic       sda_prev_q;
	logic       en_q;
	logic       master_q;
	logic       xmit_q;
	logic       ack_q;
	logic       addr_q;
	logic       arb_q;
	logic       rstop_q;
	logic       busy_q;
	logic       ack_rx_q;
	logic [7:0] tx_q;
	logic [7:0] rx_q;
	logic [7:0] sh_q;
	logic [3:0] bit_q;
	logic [7:0] cnt_q;
	logic       scl_lo_q;
	logic       sda_lo_q;
	logic       role_m_q;
	logic       byte_tx_q;
	logic       wait_ack_q;
	logic       is_stop_q;
	logic       start_req_q;
	logic       stop_req_q;
	logic       restart_req_q;
	logic       cont_q;
	logic [2:0] ev_q;
	logic [2:0] int_st_q;
	logic [2:0] int_en_q;

	logic       sel_p2;
	logic       scl_s;
	logic       sda_s;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_det;
	logic       stop_det;
	logic       cnt_done;
	logic       wr_cfg;
	logic       wr_ctl;
	logic       wr_dat;
	logic       wr_ien;
	logic       wr_icl;
	logic [7:0] ctl_rd;
	logic [7:0] rd_mux;
	logic [2:0] int_clr;
	logic [2:0] int_st_d;

	// Line location and conditioned line levels.
	assign sel_p2    = cfg_q[TWC_CFG_WID_HI] | cfg_q[TWC_CFG_POS];
	assign scl_s     = sel_p2 ? sync2_q[2] : sync2_q[0];
	assign sda_s     = sel_p2 ? sync2_q[3] : sync2_q[1];
	assign scl_rise  = scl_s & ~scl_prev_q;
	assign scl_fall  = ~scl_s & scl_prev_q;
	assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
	assign cnt_done  = (cnt_q == 8'h00);

	// Register decode; control writes are locked out while busy.
	assign wr_cfg = reg_wr & (reg_addr == TWC_ADDR_CFG);
	assign wr_ctl = reg_wr & (reg_addr == TWC_ADDR_CTL) & ~busy_q;
	assign wr_dat = reg_wr & (reg_addr == TWC_ADDR_DATA);
	assign wr_ien = reg_wr & (reg_addr == TWC_ADDR_INT_EN);
	assign wr_icl = reg_wr & (reg_addr == TWC_ADDR_INT_CL);

	// Read data selection; the acknowledge bit reads the received answer when sending.
	assign ctl_rd = {master_q, busy_q, xmit_q, (xmit_q ? ack_rx_q : ack_q),
	                 addr_q, arb_q, rstop_q, en_q};
	assign rd_mux = (reg_addr == TWC_ADDR_CFG)    ? cfg_q :
	                (reg_addr == TWC_ADDR_CTL)    ? ctl_rd :
	                (reg_addr == TWC_ADDR_DATA)   ? rx_q :
	                (reg_addr == TWC_ADDR_INT_ST) ? {5'h00, int_st_q} :
	                (reg_addr == TWC_ADDR_INT_EN) ? {5'h00, int_en_q} : 8'h00;

	// Sticky interrupt status; a new event wins over a clear in the same cycle.
	assign int_clr  = wr_icl ? reg_wdata[2:0] : 3'h0;
	assign int_st_d = (int_st_q & ~int_clr) | ev_q;

	// Two-stage synchronisers for all four pad inputs, then edge history.
	// They reset to the pulled-up idle level so that no false edge follows reset.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sync1_q    <= 4'hF;
			sync2_q    <= 4'hF;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			sync1_q    <= {p2_pin_in, p1_pin_in};
			sync2_q    <= sync1_q;
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
		end
	end

	// Configuration, data, interrupt registers, read port and pad outputs.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cfg_q           <= TWC_CFG_RST;
			tx_q            <= 8'h00;
			int_st_q        <= 3'h0;
			int_en_q        <= 3'h0;
			irq_q           <= 1'b0;
			reg_rdata_q     <= 8'h00;
			p1_pad_q        <= '0;
			p2_pad_q        <= '0;
			p1_open_drain_q <= 2'b00;
			p2_open_drain_q <= 2'b00;
			par_cfg_q       <= '0;
		end else begin
			if (wr_cfg)
				cfg_q <= reg_wdata & TWC_CFG_WMASK;
			if (wr_dat)
				tx_q <= reg_wdata;
			if (wr_ien)
				int_en_q <= reg_wdata[2:0];
			int_st_q        <= int_st_d;
			irq_q           <= |(int_st_d & int_en_q);
			reg_rdata_q     <= reg_rd ? rd_mux : 8'h00;
			p1_pad_q        <= pad_next(en_q & ~sel_p2, gpio_p1, scl_lo_q, sda_lo_q);
			p2_pad_q        <= pad_next(en_q & sel_p2, gpio_p2, scl_lo_q, sda_lo_q);
			p1_open_drain_q <= {2{en_q & ~sel_p2}};
			p2_open_drain_q <= {2{en_q & sel_p2}};
			par_cfg_q.enable <= |cfg_q[1:0];
			par_cfg_q.port0  <= |cfg_q[1:0];
			par_cfg_q.port1  <= cfg_q[TWC_CFG_WID_HI];
			par_cfg_q.port3  <= &cfg_q[1:0];
		end
	end

	// Control register writes followed by the bus sequencer; sequencer sets win.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_q <= TWC_IDLE;
			{en_q, master_q, xmit_q, ack_q, addr_q, arb_q, rstop_q, busy_q} <= 8'h00;
			{ack_rx_q, scl_lo_q, sda_lo_q, role_m_q, byte_tx_q, wait_ack_q} <= 6'h00;
			{is_stop_q, start_req_q, stop_req_q, restart_req_q, cont_q} <= 5'h00;
			rx_q  <= 8'h00;
			sh_q  <= 8'h00;
			bit_q <= 4'h0;
			cnt_q <= 8'h00;
			ev_q  <= 3'h0;
		end else begin
			ev_q <= 3'h0;
			if (!cnt_done)
				cnt_q <= cnt_q - 8'h01;
			if (wr_ctl) begin
				en_q     <= reg_wdata[TWC_CTL_EN];
				xmit_q   <= reg_wdata[TWC_CTL_XMIT];
				ack_q    <= reg_wdata[TWC_CTL_ACK];
				master_q <= reg_wdata[TWC_CTL_MSTR];
				if (reg_wdata[TWC_CTL_MSTR] & ~master_q) begin
					start_req_q <= 1'b1;
					busy_q      <= 1'b1;
				end
				if (~reg_wdata[TWC_CTL_MSTR] & master_q)
					stop_req_q <= 1'b1;
				if (reg_wdata[TWC_CTL_CONT]) begin
					busy_q        <= 1'b1;
					cont_q        <= 1'b1;
					addr_q        <= 1'b0;
					arb_q         <= 1'b0;
					rstop_q       <= 1'b0;
					restart_req_q <= reg_wdata[TWC_CTL_ARB] & reg_wdata[TWC_CTL_MSTR];
				end
			end
			unique case (state_q)
				TWC_IDLE: begin
					scl_lo_q   <= 1'b0;
					sda_lo_q   <= 1'b0;
					stop_req_q <= 1'b0;
					if (en_q && start_req_q && scl_s && sda_s) begin
						start_req_q <= 1'b0;
						role_m_q    <= 1'b1;
						byte_tx_q   <= 1'b1;
						sh_q        <= tx_q;
						sda_lo_q    <= 1'b1;
						cnt_q       <= TWC_HALF_LD;
						state_q     <= TWC_M_START;
					end else if (en_q && !master_q && start_det) begin
						role_m_q  <= 1'b0;
						byte_tx_q <= 1'b0;
						addr_q    <= 1'b1;
						busy_q    <= 1'b1;
						bit_q     <= 4'h0;
						state_q   <= TWC_S_BIT;
					end else if (!start_req_q && !wr_ctl) begin
						busy_q <= 1'b0;
						cont_q <= 1'b0;
					end
				end
				TWC_M_START: begin
					if (cnt_done) begin
						scl_lo_q <= 1'b1;
						bit_q    <= 4'h0;
						cnt_q    <= TWC_HALF_LD;
						state_q  <= TWC_M_LOW;
					end
				end
				TWC_M_LOW: begin
					sda_lo_q <= (bit_q < TWC_BIT_ACK) ? (byte_tx_q & ~sh_q[7])
					                                  : (~byte_tx_q & ack_q);
					if (cnt_done) begin
						scl_lo_q <= 1'b0;
						cnt_q    <= TWC_HALF_LD;
						state_q  <= TWC_M_HIGH;
					end
				end
				TWC_M_HIGH: begin
					if (!scl_s) begin
						cnt_q <= TWC_HALF_LD;
					end else if (cnt_done && bit_q < TWC_BIT_ACK) begin
						sh_q  <= {sh_q[6:0], sda_s};
						bit_q <= bit_q + 4'h1;
						if (byte_tx_q && sh_q[7] && !sda_s) begin
							master_q  <= 1'b0;
							arb_q     <= 1'b1;
							busy_q    <= 1'b0;
							addr_q    <= 1'b1;
							ev_q[TWC_INT_ARB] <= 1'b1;
							role_m_q  <= 1'b0;
							byte_tx_q <= 1'b0;
							sda_lo_q  <= 1'b0;
							state_q   <= TWC_S_BIT;
						end else begin
							scl_lo_q <= 1'b1;
							cnt_q    <= TWC_HALF_LD;
							if (bit_q == TWC_BIT_LAST && !byte_tx_q) begin
								rx_q       <= {sh_q[6:0], sda_s};
								ev_q[TWC_INT_BYTE] <= 1'b1;
								busy_q     <= 1'b0;
								wait_ack_q <= 1'b1;
								state_q    <= TWC_WAIT;
							end else begin
								state_q <= TWC_M_LOW;
							end
						end
					end else if (cnt_done) begin
						scl_lo_q <= 1'b1;
						cnt_q    <= TWC_HALF_LD;
						bit_q    <= 4'h0;
						if (byte_tx_q) begin
							ack_rx_q   <= ~sda_s;
							ev_q[TWC_INT_BYTE] <= 1'b1;
							busy_q     <= 1'b0;
							wait_ack_q <= 1'b0;
							state_q    <= TWC_WAIT;
						end else if (stop_req_q) begin
							is_stop_q <= 1'b1;
							state_q   <= TWC_M_COND;
						end else begin
							state_q <= TWC_M_LOW;
						end
					end
				end
				TWC_M_COND: begin
					if (bit_q == 4'h0) begin
						sda_lo_q <= is_stop_q;
						if (cnt_done) begin
							scl_lo_q <= 1'b0;
							bit_q    <= 4'h1;
							cnt_q    <= TWC_HALF_LD;
						end
					end else if (bit_q == 4'h1) begin
						if (!scl_s) begin
							cnt_q <= TWC_HALF_LD;
						end else if (cnt_done) begin
							sda_lo_q <= ~is_stop_q;
							bit_q    <= 4'h2;
							cnt_q    <= TWC_HALF_LD;
						end
					end else if (cnt_done) begin
						cnt_q <= TWC_HALF_LD;
						if (is_stop_q) begin
							busy_q     <= 1'b0;
							role_m_q   <= 1'b0;
							stop_req_q <= 1'b0;
							state_q    <= TWC_IDLE;
						end else begin
							state_q <= TWC_M_START;
						end
					end
				end
				TWC_S_BIT: begin
					if (start_det) begin
						addr_q    <= 1'b1;
						byte_tx_q <= 1'b0;
						sda_lo_q  <= 1'b0;
						bit_q     <= 4'h0;
					end else if (stop_det) begin
						if (!byte_tx_q && ack_q) begin
							rstop_q <= 1'b1;
							ev_q[TWC_INT_STOP] <= 1'b1;
						end
						sda_lo_q <= 1'b0;
						busy_q   <= 1'b0;
						state_q  <= TWC_IDLE;
					end else if (scl_rise) begin
						if (bit_q < TWC_BIT_ACK)
							sh_q <= {sh_q[6:0], sda_s};
						if (bit_q == TWC_BIT_ACK && byte_tx_q)
							ack_rx_q <= ~sda_s;
						bit_q <= bit_q + 4'h1;
					end else if (scl_fall) begin
						if (bit_q == TWC_BIT_ACK && !byte_tx_q) begin
							rx_q       <= sh_q;
							scl_lo_q   <= 1'b1;
							ev_q[TWC_INT_BYTE] <= 1'b1;
							busy_q     <= 1'b0;
							wait_ack_q <= 1'b1;
							state_q    <= TWC_WAIT;
						end else if (bit_q == TWC_BIT_END && byte_tx_q) begin
							scl_lo_q   <= 1'b1;
							sda_lo_q   <= 1'b0;
							ev_q[TWC_INT_BYTE] <= 1'b1;
							busy_q     <= 1'b0;
							wait_ack_q <= 1'b0;
							state_q    <= TWC_WAIT;
						end else if (bit_q == TWC_BIT_END) begin
							bit_q     <= 4'h0;
							sh_q      <= tx_q;
							byte_tx_q <= xmit_q;
							sda_lo_q  <= xmit_q & ~tx_q[7];
						end else if (byte_tx_q) begin
							sda_lo_q <= (bit_q < TWC_BIT_ACK) & ~sh_q[7];
						end
					end
				end
				TWC_WAIT: begin
					scl_lo_q <= 1'b1;
					cnt_q    <= TWC_HALF_LD;
					if (role_m_q && stop_req_q && !cont_q) begin
						bit_q     <= wait_ack_q ? TWC_BIT_ACK : 4'h0;
						is_stop_q <= 1'b1;
						busy_q    <= 1'b1;
						state_q   <= wait_ack_q ? TWC_M_LOW : TWC_M_COND;
					end else if (cont_q) begin
						cont_q <= 1'b0;
						if (!role_m_q) begin
							scl_lo_q <= 1'b0;
							state_q  <= TWC_S_BIT;
							if (wait_ack_q) begin
								sda_lo_q <= ack_q;
								bit_q    <= TWC_BIT_ACK;
							end else begin
								sh_q      <= tx_q;
								byte_tx_q <= xmit_q;
								sda_lo_q  <= xmit_q & ~tx_q[7];
								bit_q     <= 4'h0;
							end
						end else if (restart_req_q) begin
							restart_req_q <= 1'b0;
							is_stop_q     <= 1'b0;
							byte_tx_q     <= 1'b1;
							sh_q          <= tx_q;
							bit_q         <= 4'h0;
							state_q       <= TWC_M_COND;
						end else if (wait_ack_q) begin
							bit_q   <= TWC_BIT_ACK;
							state_q <= TWC_M_LOW;
						end else begin
							sh_q      <= tx_q;
							byte_tx_q <= xmit_q;
							bit_q     <= 4'h0;
							state_q   <= TWC_M_LOW;
						end
					end
				end
			endcase
			// Disabling the function drops the lines back to the GPIO logic at once.
			if (!en_q && state_q != TWC_IDLE) begin
				state_q  <= TWC_IDLE;
				role_m_q <= 1'b0;
			end
		end
	end

endmodule : twc_ctrl

`default_nettype wire

// File: tb/twc_peer.sv
// Purpose: Behavioural device on the far side of the two-wire bus.
// Assumes: Lines carry pull-ups, so a released line reads high.
// Notes:   Receives while send is low, transmits txb while send is high.
`timescale 1ns/100ps
`default_nettype none

module twc_peer (
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       fight,
	input  wire logic       send,
	input  wire logic [7:0] txb,
	output logic            sda_lo,
	output logic      [7:0] rx_byte,
	output logic            ack_got,
	output logic            stop_seen
);
	logic [3:0] cnt;
	logic [3:0] slot;
	logic       nak;

	// Idle until the first start condition.
	initial begin
		cnt = 4'h0;
		slot = 4'h9;
		rx_byte = 8'h00;
		ack_got = 1'b0;
		stop_seen = 1'b0;
		nak = 1'b0;
	end

	// A data edge while the clock is high marks a start or a stop.
	always @(negedge sda) if (scl) begin
		cnt = 4'h0;
		slot = 4'h9;
		stop_seen = 1'b0;
		nak = 1'b0;
	end
	always @(posedge sda) if (scl) begin
		slot = 4'h9;
		stop_seen = 1'b1;
	end

	// Bits are taken on the rising clock, MSB first, then the acknowledge slot.
	always @(posedge scl) begin
		if (cnt < 4'h8 && !send) rx_byte = {rx_byte[6:0], sda};
		if (cnt == 4'h8) ack_got = !sda;
		// A transmitting peer lets go of data after a not-acknowledge.
		if (cnt == 4'h8 && send && sda) nak = 1'b1;
		cnt = (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
	end

	// Data only changes while the clock is low; a competing master drives zeros.
	always @(negedge scl) slot = cnt;
	assign sda_lo = (slot < 4'h8) ? (fight || (send && !nak && !txb[3'd7 - slot[2:0]]))
		: (slot == 4'h8 && !send);

endmodule : twc_peer
`default_nettype wire

// File: tb/twc_ctrl_chk.sv
// Purpose: Port-level assertions for the two-wire controller.
// Assumes: Single mclk domain, resetn asynchronous active low.
// Notes:   Attached to every twc_ctrl instance by the bind below.
`timescale 1ns/100ps
`default_nettype none

module twc_ctrl_chk
	import twc_pkg::*;
(
	input wire logic       mclk,
	input wire logic       resetn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata_q,
	input wire twc_pad_t   gpio_p1,
	input wire twc_pad_t   p1_pad_q,
	input wire twc_pad_t   p2_pad_q,
	input wire logic [1:0] p1_open_drain_q,
	input wire logic [1:0] p2_open_drain_q,
	input wire twc_par_t   par_cfg_q,
	input wire logic       irq_q
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	AST_RST_CLEAR: assert property ($rose(resetn) |-> par_cfg_q == 4'h0 &&
		p1_open_drain_q == 2'h0 && p2_open_drain_q == 2'h0) else $error("config not clear");
	AST_PAR_WIDTH: assert property (par_cfg_q.enable == par_cfg_q.port0 &&
		(!par_cfg_q.port3 || par_cfg_q.port1) && (!par_cfg_q.port1 || par_cfg_q.port0))
		else $error("parallel select inconsistent");
	AST_OD_ONE_PORT: assert property (!(p1_open_drain_q[0] && p2_open_drain_q[0]) &&
		p1_open_drain_q[1] == p1_open_drain_q[0]) else $error("open drain on both ports");
	AST_WIDE_PORT2: assert property (par_cfg_q.port1 && $stable(par_cfg_q) |->
		p1_open_drain_q == 2'h0) else $error("serial lines left on port 1");
	AST_LOW_ONLY: assert property (p2_open_drain_q[0] && $past(p2_open_drain_q[0]) |->
		p2_pad_q.o == 2'h0) else $error("serial line driven high");
	AST_GPIO_PASS: assert property ($past(resetn) && !p1_open_drain_q[0] &&
		!$past(p1_open_drain_q[0]) |-> p1_pad_q == $past(gpio_p1))
		else $error("gpio drive not passed");
	AST_IRQ_HOLD: assert property ($rose(irq_q) && p2_pad_q.oe[0] |->
		p2_pad_q.oe[0] [*8]) else $error("clock released during interrupt");
	AST_RD_PULSE: assert property (!$past(reg_rd) |-> reg_rdata_q == 8'h00)
		else $error("read data outside its cycle");
	AST_UNMAPPED: assert property (reg_rd && reg_addr == 8'h3F |=> reg_rdata_q == 8'h00)
		else $error("unmapped read not zero");
	AST_START: assert property (reg_wr && reg_addr == TWC_ADDR_CTL && reg_wdata[7] &&
		!reg_wdata[6] && reg_wdata[0] && p2_open_drain_q == 2'h3 && p2_pad_q.oe == 2'h0
		|-> ##[1:6] p2_pad_q.oe[1]) else $error("no start after master write");

	// Main scenarios reached.
	COV_IRQ: cover property ($rose(irq_q));
	COV_DATA_LOW: cover property (p2_open_drain_q == 2'h3 && p2_pad_q.oe[1]);
	COV_WIDE: cover property (par_cfg_q.port3);

endmodule : twc_ctrl_chk

bind twc_ctrl twc_ctrl_chk u_chk (
	.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .gpio_p1(gpio_p1),
	.p1_pad_q(p1_pad_q), .p2_pad_q(p2_pad_q), .p1_open_drain_q(p1_open_drain_q),
	.p2_open_drain_q(p2_open_drain_q), .par_cfg_q(par_cfg_q), .irq_q(irq_q)
);
`default_nettype wire

// File: tb/twc_ctrl_tb_top.sv
// Purpose: Self-checking bench for the two-wire controller and pin configuration.
// Assumes: Peer model on port 2 lines with pull-ups; 25 MHz mclk.
// Notes:   Register tasks follow the one-cycle strobe port.
`timescale 1ns/100ps
`default_nettype none

`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end

module twc_ctrl_tb_top;
	import twc_pkg::*;

	logic       mclk;
	logic       resetn;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata_q;
	twc_pad_t   gpio_p1;
	twc_pad_t   gpio_p2;
	twc_pad_t   p1_pad_q;
	twc_pad_t   p2_pad_q;
	logic [1:0] p1_open_drain_q;
	logic [1:0] p2_open_drain_q;
	twc_par_t   par_cfg_q;
	logic       irq_q;
	logic [1:0] l1;
	logic       scl2;
	logic       sda2;
	logic       fight;
	logic       send;
	logic       pt_lo;
	logic [7:0] pt_rx;
	logic       pt_ack;
	logic       pt_stop;
	int         fails;
	int         tests_run;
	logic [7:0] cfgs [4] = '{8'h00, 8'h80, 8'h02, 8'h82};

	// Wired-AND lines: low when any party pulls low, else the pull-up wins.
	assign l1   = ~(p1_pad_q.oe & ~p1_pad_q.o);
	assign scl2 = ~(p2_pad_q.oe[0] & ~p2_pad_q.o[0]);
	assign sda2 = ~((p2_pad_q.oe[1] & ~p2_pad_q.o[1]) | pt_lo);

	twc_ctrl u_dut (
		.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .p1_pin_in(l1),
		.p2_pin_in({sda2, scl2}), .gpio_p1(gpio_p1), .gpio_p2(gpio_p2), .p1_pad_q(p1_pad_q),
		.p2_pad_q(p2_pad_q), .p1_open_drain_q(p1_open_drain_q),
		.p2_open_drain_q(p2_open_drain_q), .par_cfg_q(par_cfg_q), .irq_q(irq_q)
	);
	twc_peer u_peer (
		.scl(scl2), .sda(sda2), .fight(fight), .send(send), .txb(8'h5A),
		.sda_lo(pt_lo), .rx_byte(pt_rx), .ack_got(pt_ack), .stop_seen(pt_stop)
	);

	// Clock generator.
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// Ends the run with the counts and the verdict.
	task final_report;
		$display("Comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : final_report

	// One-cycle register write.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr

	// One-cycle register read, compared under a mask in the following cycle.
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rdata_q & m, e)
	endtask : rd

	// Bounded wait for the interrupt output, then room before any write.
	task automatic wait_irq;
		int n;
		n = 0;
		while (irq_q !== 1'b1 && n < 8000) begin
			@(posedge mclk);
			n++;
		end
		`CHK(irq_q, 1'b1)
		repeat (10) @(posedge mclk);
	endtask : wait_irq

	// Watchdog sized well past the longest expected run.
	initial begin
		#1600000;
		fails++;
		final_report();
	end

	// Main sequence.
	initial begin
		logic [1:0] w;
		logic       p2;
		int         n;
		fails = 0;
		tests_run = 0;
		resetn = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		gpio_p1 = 4'h3;
		gpio_p2 = 4'h0;
		fight = 1'b0;
		send = 1'b0;
		repeat (10) @(posedge mclk);
		resetn <= 1'b1;
		repeat (3) @(posedge mclk);
		rd(TWC_ADDR_CFG, 8'h00, 8'hFF);
		rd(TWC_ADDR_CTL, 8'h00, 8'hFF);
		rd(8'h3F, 8'h00, 8'hFF);
		for (int i = 0; i < 4; i++) begin
			w = i[1:0];
			wr(TWC_ADDR_CFG, {6'h00, w});
			repeat (3) @(posedge mclk);
			`CHK(par_cfg_q, {|w, |w, w[1], &w})
		end
		wr(TWC_ADDR_CFG, 8'hFF);
		rd(TWC_ADDR_CFG, TWC_CFG_WMASK, 8'hFF);
		`CHK({p2_open_drain_q, p1_open_drain_q}, 4'h0)
		for (int i = 0; i < 4; i++) begin
			p2 = cfgs[i][7] | cfgs[i][1];
			wr(TWC_ADDR_CFG, cfgs[i]);
			wr(TWC_ADDR_CTL, 8'h01);
			repeat (3) @(posedge mclk);
			`CHK({p2_open_drain_q, p1_open_drain_q}, p2 ? 4'hC : 4'h3)
			`CHK(p1_pad_q, p2 ? gpio_p1 : 4'h0)
			wr(TWC_ADDR_CTL, 8'h00);
		end
		rd(TWC_ADDR_INT_EN, 8'h00, 8'hFF);
		wr(TWC_ADDR_INT_EN, 8'h07);
		rd(TWC_ADDR_INT_EN, 8'h07, 8'h07);
		wr(TWC_ADDR_CFG, 8'h80);
		wr(TWC_ADDR_CTL, 8'h01);
		wr(TWC_ADDR_INT_CL, 8'h07);
		wr(TWC_ADDR_DATA, 8'hA5);
		wr(TWC_ADDR_CTL, 8'hA1);
		wait_irq();
		`CHK(pt_rx, 8'hA5)
		`CHK(scl2, 1'b0)
		rd(TWC_ADDR_INT_ST, 8'h01, 8'h07);
		rd(TWC_ADDR_CTL, 8'h91, 8'hD1);
		wr(TWC_ADDR_INT_CL, 8'h01);
		repeat (3) @(posedge mclk);
		`CHK(irq_q, 1'b0)
		wr(TWC_ADDR_DATA, 8'h3C);
		send <= 1'b1;
		wr(TWC_ADDR_CTL, 8'hD1);
		repeat (2) @(posedge mclk);
		rd(TWC_ADDR_CTL, 8'h40, 8'h40);
		wait_irq();
		rd(TWC_ADDR_DATA, 8'h5A, 8'hFF);
		wr(TWC_ADDR_INT_CL, 8'h01);
		wr(TWC_ADDR_CTL, 8'hD1);
		wait_irq();
		`CHK(pt_ack, 1'b1)
		wr(TWC_ADDR_INT_EN, 8'h00);
		repeat (3) @(posedge mclk);
		`CHK(irq_q, 1'b0)
		wr(TWC_ADDR_INT_EN, 8'h07);
		repeat (3) @(posedge mclk);
		`CHK(irq_q, 1'b1)
		wr(TWC_ADDR_INT_CL, 8'h07);
		wr(TWC_ADDR_CTL, 8'h01);
		n = 0;
		while (pt_stop !== 1'b1 && n < 3000) begin
			@(posedge mclk);
			n++;
		end
		`CHK(pt_stop, 1'b1)
		`CHK(pt_ack, 1'b0)
		send <= 1'b0;
		repeat (300) @(posedge mclk);
		wr(TWC_ADDR_INT_CL, 8'h07);
		fight <= 1'b1;
		wr(TWC_ADDR_DATA, 8'hFF);
		wr(TWC_ADDR_CTL, 8'h81);
		wait_irq();
		rd(TWC_ADDR_INT_ST, 8'h04, 8'h04);
		rd(TWC_ADDR_CTL, 8'h0C, 8'hCC);
		fight <= 1'b0;
		wr(TWC_ADDR_CTL, 8'h00);
		wr(TWC_ADDR_INT_CL, 8'h07);
		repeat (20) @(posedge mclk);
		final_report();
	end

endmodule : twc_ctrl_tb_top
`default_nettype wire
